// file: verilog/iprb_pkg.sv
package iprb_pkg;
  // Register byte offsets (chosen map, one aligned word each)
  localparam logic [4:0] OFF_SPI2  = 5'h00;
  localparam logic [4:0] OFF_CAP   = 5'h04;
  localparam logic [4:0] OFF_CMP   = 5'h08;
  localparam logic [4:0] OFF_PMP   = 5'h0C;
  localparam logic [4:0] OFF_I2C2  = 5'h10;
  localparam logic [4:0] OFF_EXT   = 5'h14;
  localparam logic [4:0] OFF_RTC   = 5'h18;
  // Implemented-bit masks per register
  localparam logic [15:0] MASK_SPI2 = 16'h0077;
  localparam logic [15:0] MASK_CAP  = 16'h7770;
  localparam logic [15:0] MASK_CMP  = 16'h7777;
  localparam logic [15:0] MASK_PMP  = 16'h0077;
  localparam logic [15:0] MASK_I2C2 = 16'h0770;
  localparam logic [15:0] MASK_EXT  = 16'h0770;
  localparam logic [15:0] MASK_RTC  = 16'h0700;
  // Field reset value: level four
  localparam logic [2:0]  LEVEL_RST = 3'h4;
  localparam logic [2:0]  LEVEL_OFF = 3'h0;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// file: verilog/iprb_regs.sv
`timescale 1ns/1ns
// Functional notes
// - Code 111 selects level seven, the highest.
// - Code 001 is level one; other codes equal their binary value.
// - Code 000 disables the source entirely.
// - Unassigned bits read zero; writes to them are ignored.
// - Each field resets to 100, level four.
// - Field bits are read/write and read back the last write.
// - Register 0: serial event bits 6-4, fault bits 2-0.
// - Register 1: capture 5,4,3 at bits 14-12, 10-8, 6-4.
// - Register 2: compare 7,6,5 upper fields, capture 6 bits 2-0.
// - Register 4: second I2C master bits 10-8, slave bits 6-4.
// - Register 6: calendar clock bits 10-8 only.
module iprb_regs (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // AXI4-Lite write address
  input  wire logic [4:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [4:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Priority levels toward arbitration
  output logic [2:0]       serial_if2_event_level_o,
  output logic [2:0]       serial_if2_fault_level_o,
  output logic [2:0]       capture_ch5_level_o,
  output logic [2:0]       capture_ch4_level_o,
  output logic [2:0]       capture_ch3_level_o,
  output logic [2:0]       compare_ch7_level_o,
  output logic [2:0]       compare_ch6_level_o,
  output logic [2:0]       compare_ch5_level_o,
  output logic [2:0]       capture_ch6_level_o,
  output logic [2:0]       parallel_port_level_o,
  output logic [2:0]       compare_ch8_level_o,
  output logic [2:0]       i2c_second_master_level_o,
  output logic [2:0]       i2c_second_slave_level_o,
  output logic [2:0]       external_irq4_level_o,
  output logic [2:0]       external_irq3_level_o,
  output logic [2:0]       calendar_clock_level_o,
  // Per-source enable: level nonzero
  output logic [15:0]      source_enable_o
);

  logic [15:0] spi2_priority_ctrl_q;
  logic [15:0] capture_3_to_5_priority_ctrl_q;
  logic [15:0] compare_5_to_7_capture_6_priority_ctrl_q;
  logic [15:0] parallel_port_compare_8_priority_ctrl_q;
  logic [15:0] i2c_second_priority_ctrl_q;
  logic [15:0] ext_irq_3_4_priority_ctrl_q;
  logic [15:0] rtc_priority_ctrl_q;

  logic        aw_held_q;
  logic [4:0]  aw_addr_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        do_write;
  logic        wr_hit;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic [15:0] rd_val;
  logic        rd_hit;

  // Reset value of a register: each field 100
  function automatic logic [15:0] rst_of(input logic [15:0] m);
    rst_of = m & 16'h4444;
  endfunction

  // Merge masked write, byte lanes honoured
  function automatic logic [15:0] merge(input logic [15:0] cur,
                                        input logic [15:0] m,
                                        input logic [15:0] d,
                                        input logic [15:0] lanes);
    logic [15:0] en;
    en = m & lanes;
    merge = (cur & ~en) | (d & en);
  endfunction

  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid_o;
  assign wval     = w_data_q[15:0];
  assign wmask    = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  always_comb begin
    wr_hit = 1'b1;
    if (aw_addr_q[4:2] == iprb_pkg::OFF_SPI2[4:2]) begin
    end else if (aw_addr_q[4:2] == iprb_pkg::OFF_CAP[4:2]) begin
    end else if (aw_addr_q[4:2] == iprb_pkg::OFF_CMP[4:2]) begin
    end else if (aw_addr_q[4:2] == iprb_pkg::OFF_PMP[4:2]) begin
    end else if (aw_addr_q[4:2] == iprb_pkg::OFF_I2C2[4:2]) begin
    end else if (aw_addr_q[4:2] == iprb_pkg::OFF_EXT[4:2]) begin
    end else if (aw_addr_q[4:2] == iprb_pkg::OFF_RTC[4:2]) begin
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Write address and data taken independently
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      aw_held_q       <= 1'b0;
      aw_addr_q       <= 5'h00;
      s_axi_awready_o <= 1'b0;
    end else begin
      s_axi_awready_o <= !aw_held_q && !s_axi_awready_o;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_q       <= 1'b1;
        aw_addr_q       <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      w_held_q       <= 1'b0;
      w_data_q       <= 32'h0000_0000;
      w_strb_q       <= 4'h0;
      s_axi_wready_o <= 1'b0;
    end else begin
      s_axi_wready_o <= !w_held_q && !s_axi_wready_o;
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_q       <= 1'b1;
        w_data_q       <= s_axi_wdata_i;
        w_strb_q       <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= iprb_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_hit ? iprb_pkg::RESP_OKAY : iprb_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Register storage; masks keep unassigned bits at zero
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      spi2_priority_ctrl_q                     <= rst_of(iprb_pkg::MASK_SPI2);
      capture_3_to_5_priority_ctrl_q           <= rst_of(iprb_pkg::MASK_CAP);
      compare_5_to_7_capture_6_priority_ctrl_q <= rst_of(iprb_pkg::MASK_CMP);
      parallel_port_compare_8_priority_ctrl_q  <= rst_of(iprb_pkg::MASK_PMP);
      i2c_second_priority_ctrl_q               <= rst_of(iprb_pkg::MASK_I2C2);
      ext_irq_3_4_priority_ctrl_q              <= rst_of(iprb_pkg::MASK_EXT);
      rtc_priority_ctrl_q                      <= rst_of(iprb_pkg::MASK_RTC);
    end else if (do_write) begin
      if (aw_addr_q[4:2] == iprb_pkg::OFF_SPI2[4:2]) begin
        spi2_priority_ctrl_q <= merge(spi2_priority_ctrl_q,
                                      iprb_pkg::MASK_SPI2, wval, wmask);
      end else if (aw_addr_q[4:2] == iprb_pkg::OFF_CAP[4:2]) begin
        capture_3_to_5_priority_ctrl_q <= merge(capture_3_to_5_priority_ctrl_q,
                                                iprb_pkg::MASK_CAP, wval, wmask);
      end else if (aw_addr_q[4:2] == iprb_pkg::OFF_CMP[4:2]) begin
        compare_5_to_7_capture_6_priority_ctrl_q <=
          merge(compare_5_to_7_capture_6_priority_ctrl_q, iprb_pkg::MASK_CMP, wval, wmask);
      end else if (aw_addr_q[4:2] == iprb_pkg::OFF_PMP[4:2]) begin
        parallel_port_compare_8_priority_ctrl_q <=
          merge(parallel_port_compare_8_priority_ctrl_q, iprb_pkg::MASK_PMP, wval, wmask);
      end else if (aw_addr_q[4:2] == iprb_pkg::OFF_I2C2[4:2]) begin
        i2c_second_priority_ctrl_q <= merge(i2c_second_priority_ctrl_q,
                                            iprb_pkg::MASK_I2C2, wval, wmask);
      end else if (aw_addr_q[4:2] == iprb_pkg::OFF_EXT[4:2]) begin
        ext_irq_3_4_priority_ctrl_q <= merge(ext_irq_3_4_priority_ctrl_q,
                                             iprb_pkg::MASK_EXT, wval, wmask);
      end else if (aw_addr_q[4:2] == iprb_pkg::OFF_RTC[4:2]) begin
        rtc_priority_ctrl_q <= merge(rtc_priority_ctrl_q,
                                     iprb_pkg::MASK_RTC, wval, wmask);
      end
    end
  end

  // Read decode
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 16'h0000;
    if (s_axi_araddr_i[4:2] == iprb_pkg::OFF_SPI2[4:2]) begin
      rd_val = spi2_priority_ctrl_q;
    end else if (s_axi_araddr_i[4:2] == iprb_pkg::OFF_CAP[4:2]) begin
      rd_val = capture_3_to_5_priority_ctrl_q;
    end else if (s_axi_araddr_i[4:2] == iprb_pkg::OFF_CMP[4:2]) begin
      rd_val = compare_5_to_7_capture_6_priority_ctrl_q;
    end else if (s_axi_araddr_i[4:2] == iprb_pkg::OFF_PMP[4:2]) begin
      rd_val = parallel_port_compare_8_priority_ctrl_q;
    end else if (s_axi_araddr_i[4:2] == iprb_pkg::OFF_I2C2[4:2]) begin
      rd_val = i2c_second_priority_ctrl_q;
    end else if (s_axi_araddr_i[4:2] == iprb_pkg::OFF_EXT[4:2]) begin
      rd_val = ext_irq_3_4_priority_ctrl_q;
    end else if (s_axi_araddr_i[4:2] == iprb_pkg::OFF_RTC[4:2]) begin
      rd_val = rtc_priority_ctrl_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read: arready pulses while idle; data one cycle after the address
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= iprb_pkg::RESP_OKAY;
    end else begin
      s_axi_arready_o <= !s_axi_rvalid_o && !s_axi_arready_o && !s_axi_arvalid_i
                         ? 1'b1 : (!s_axi_rvalid_o && !s_axi_arready_o);
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= {16'h0000, rd_val};
        s_axi_rresp_o   <= rd_hit ? iprb_pkg::RESP_OKAY : iprb_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // registered level outputs, valid cycle after storage updates
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      serial_if2_event_level_o  <= iprb_pkg::LEVEL_RST;
      serial_if2_fault_level_o  <= iprb_pkg::LEVEL_RST;
      capture_ch5_level_o       <= iprb_pkg::LEVEL_RST;
      capture_ch4_level_o       <= iprb_pkg::LEVEL_RST;
      capture_ch3_level_o       <= iprb_pkg::LEVEL_RST;
      compare_ch7_level_o       <= iprb_pkg::LEVEL_RST;
      compare_ch6_level_o       <= iprb_pkg::LEVEL_RST;
      compare_ch5_level_o       <= iprb_pkg::LEVEL_RST;
      capture_ch6_level_o       <= iprb_pkg::LEVEL_RST;
      parallel_port_level_o     <= iprb_pkg::LEVEL_RST;
      compare_ch8_level_o       <= iprb_pkg::LEVEL_RST;
      i2c_second_master_level_o <= iprb_pkg::LEVEL_RST;
      i2c_second_slave_level_o  <= iprb_pkg::LEVEL_RST;
      external_irq4_level_o     <= iprb_pkg::LEVEL_RST;
      external_irq3_level_o     <= iprb_pkg::LEVEL_RST;
      calendar_clock_level_o    <= iprb_pkg::LEVEL_RST;
    end else begin
      serial_if2_event_level_o  <= spi2_priority_ctrl_q[6:4];
      serial_if2_fault_level_o  <= spi2_priority_ctrl_q[2:0];
      capture_ch5_level_o       <= capture_3_to_5_priority_ctrl_q[14:12];
      capture_ch4_level_o       <= capture_3_to_5_priority_ctrl_q[10:8];
      capture_ch3_level_o       <= capture_3_to_5_priority_ctrl_q[6:4];
      compare_ch7_level_o       <= compare_5_to_7_capture_6_priority_ctrl_q[14:12];
      compare_ch6_level_o       <= compare_5_to_7_capture_6_priority_ctrl_q[10:8];
      compare_ch5_level_o       <= compare_5_to_7_capture_6_priority_ctrl_q[6:4];
      capture_ch6_level_o       <= compare_5_to_7_capture_6_priority_ctrl_q[2:0];
      parallel_port_level_o     <= parallel_port_compare_8_priority_ctrl_q[6:4];
      compare_ch8_level_o       <= parallel_port_compare_8_priority_ctrl_q[2:0];
      i2c_second_master_level_o <= i2c_second_priority_ctrl_q[10:8];
      i2c_second_slave_level_o  <= i2c_second_priority_ctrl_q[6:4];
      external_irq4_level_o     <= ext_irq_3_4_priority_ctrl_q[10:8];
      external_irq3_level_o     <= ext_irq_3_4_priority_ctrl_q[6:4];
      calendar_clock_level_o    <= rtc_priority_ctrl_q[10:8];
    end
  end

  // level equals code; zero means disabled
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      source_enable_o <= 16'hFFFF;
    end else begin
      source_enable_o <= {
        spi2_priority_ctrl_q[6:4] != iprb_pkg::LEVEL_OFF,
        spi2_priority_ctrl_q[2:0] != iprb_pkg::LEVEL_OFF,
        capture_3_to_5_priority_ctrl_q[14:12] != iprb_pkg::LEVEL_OFF,
        capture_3_to_5_priority_ctrl_q[10:8] != iprb_pkg::LEVEL_OFF,
        capture_3_to_5_priority_ctrl_q[6:4] != iprb_pkg::LEVEL_OFF,
        compare_5_to_7_capture_6_priority_ctrl_q[14:12] != iprb_pkg::LEVEL_OFF,
        compare_5_to_7_capture_6_priority_ctrl_q[10:8] != iprb_pkg::LEVEL_OFF,
        compare_5_to_7_capture_6_priority_ctrl_q[6:4] != iprb_pkg::LEVEL_OFF,
        compare_5_to_7_capture_6_priority_ctrl_q[2:0] != iprb_pkg::LEVEL_OFF,
        parallel_port_compare_8_priority_ctrl_q[6:4] != iprb_pkg::LEVEL_OFF,
        parallel_port_compare_8_priority_ctrl_q[2:0] != iprb_pkg::LEVEL_OFF,
        i2c_second_priority_ctrl_q[10:8] != iprb_pkg::LEVEL_OFF,
        i2c_second_priority_ctrl_q[6:4] != iprb_pkg::LEVEL_OFF,
        ext_irq_3_4_priority_ctrl_q[10:8] != iprb_pkg::LEVEL_OFF,
        ext_irq_3_4_priority_ctrl_q[6:4] != iprb_pkg::LEVEL_OFF,
        rtc_priority_ctrl_q[10:8] != iprb_pkg::LEVEL_OFF};
    end
  end

  property p_reserved_zero;
    @(posedge clk_i) disable iff (!resetn_i)
      s_axi_rvalid_o |-> (s_axi_rdata_o[31:16] == 16'h0000) && !s_axi_rdata_o[15]
                         && !s_axi_rdata_o[11] && !s_axi_rdata_o[7] && !s_axi_rdata_o[3];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read nonzero");

  property p_rtc_mask;
    @(posedge clk_i) disable iff (!resetn_i)
      (rtc_priority_ctrl_q & ~iprb_pkg::MASK_RTC) == 16'h0000;
  endproperty
  a_rtc_mask: assert property (p_rtc_mask) else $error("calendar register stray bit");

  // output follows register one cycle later
  property p_follow;
    @(posedge clk_i) disable iff (!resetn_i)
      $past(resetn_i) |-> calendar_clock_level_o == $past(rtc_priority_ctrl_q[10:8]);
  endproperty
  a_follow: assert property (p_follow) else $error("level output lags wrongly");

  property p_disable;
    @(posedge clk_i) disable iff (!resetn_i)
      ##1 (capture_ch3_level_o == 3'h0) |-> !source_enable_o[11];
  endproperty
  a_disable: assert property (p_disable) else $error("zero level left enabled");

  property p_write_spi2;
    @(posedge clk_i) disable iff (!resetn_i)
      (do_write && aw_addr_q[4:2] == 3'h0 && w_strb_q[0])
        |=> spi2_priority_ctrl_q[7:0] == ($past(w_data_q[7:0]) & 8'h77);
  endproperty
  a_write_spi2: assert property (p_write_spi2) else $error("write not stored");

  // levels back to four under reset
  property p_reset_level;
    @(posedge clk_i)
      !resetn_i |=> (capture_ch5_level_o == iprb_pkg::LEVEL_RST)
                    && (calendar_clock_level_o == iprb_pkg::LEVEL_RST);
  endproperty
  a_reset_level: assert property (p_reset_level) else $error("level not four after reset");

endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic              clk_i    = 1'b0;
  logic              resetn_i = 1'b0;
  logic [4:0]        aw_addr  = 5'h00;
  logic              aw_valid = 1'b0;
  logic              aw_ready;
  logic [31:0]       w_data   = 32'h00000000;
  logic [3:0]        w_strb   = 4'h0;
  logic              w_valid  = 1'b0;
  logic              w_ready;
  logic [1:0]        b_resp;
  logic              b_valid;
  logic              b_ready  = 1'b0;
  logic [4:0]        ar_addr  = 5'h00;
  logic              ar_valid = 1'b0;
  logic              ar_ready;
  logic [31:0]       r_data;
  logic [1:0]        r_resp;
  logic              r_valid;
  logic              r_ready  = 1'b0;
  logic [15:0][2:0]  lv;
  logic [15:0]       en;
  logic [15:0]       sh [7];
  int                miscompares = 0;
  int                checks      = 0;
  int                cyc         = 0;

  localparam logic [15:0] MASKS [7] = '{iprb_pkg::MASK_SPI2, iprb_pkg::MASK_CAP,
    iprb_pkg::MASK_CMP, iprb_pkg::MASK_PMP, iprb_pkg::MASK_I2C2, iprb_pkg::MASK_EXT,
    iprb_pkg::MASK_RTC};
  localparam logic [4:0] OFFS [7] = '{iprb_pkg::OFF_SPI2, iprb_pkg::OFF_CAP,
    iprb_pkg::OFF_CMP, iprb_pkg::OFF_PMP, iprb_pkg::OFF_I2C2, iprb_pkg::OFF_EXT,
    iprb_pkg::OFF_RTC};

  iprb_regs dut (
    .clk_i                     (clk_i),
    .resetn_i                  (resetn_i),
    .s_axi_awaddr_i            (aw_addr),
    .s_axi_awvalid_i           (aw_valid),
    .s_axi_awready_o           (aw_ready),
    .s_axi_wdata_i             (w_data),
    .s_axi_wstrb_i             (w_strb),
    .s_axi_wvalid_i            (w_valid),
    .s_axi_wready_o            (w_ready),
    .s_axi_bresp_o             (b_resp),
    .s_axi_bvalid_o            (b_valid),
    .s_axi_bready_i            (b_ready),
    .s_axi_araddr_i            (ar_addr),
    .s_axi_arvalid_i           (ar_valid),
    .s_axi_arready_o           (ar_ready),
    .s_axi_rdata_o             (r_data),
    .s_axi_rresp_o             (r_resp),
    .s_axi_rvalid_o            (r_valid),
    .s_axi_rready_i            (r_ready),
    .serial_if2_event_level_o  (lv[15]),
    .serial_if2_fault_level_o  (lv[14]),
    .capture_ch5_level_o       (lv[13]),
    .capture_ch4_level_o       (lv[12]),
    .capture_ch3_level_o       (lv[11]),
    .compare_ch7_level_o       (lv[10]),
    .compare_ch6_level_o       (lv[9]),
    .compare_ch5_level_o       (lv[8]),
    .capture_ch6_level_o       (lv[7]),
    .parallel_port_level_o     (lv[6]),
    .compare_ch8_level_o       (lv[5]),
    .i2c_second_master_level_o (lv[4]),
    .i2c_second_slave_level_o  (lv[3]),
    .external_irq4_level_o     (lv[2]),
    .external_irq3_level_o     (lv[1]),
    .calendar_clock_level_o    (lv[0]),
    .source_enable_o           (en)
  );

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic test_done();
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Generous ceiling; whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  function automatic logic [47:0] exp_lv();
    return {sh[0][6:4], sh[0][2:0], sh[1][14:12], sh[1][10:8], sh[1][6:4],
            sh[2][14:12], sh[2][10:8], sh[2][6:4], sh[2][2:0], sh[3][6:4], sh[3][2:0],
            sh[4][10:8], sh[4][6:4], sh[5][10:8], sh[5][6:4], sh[6][10:8]};
  endfunction

  function automatic void mdl_reset();
    for (int i = 0; i < 7; i++) sh[i] = {4{1'b0, iprb_pkg::LEVEL_RST}} & MASKS[i];
  endfunction

  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    bit b_d;
    b_d = 1'b0;
    @(posedge clk_i);
    aw_addr  <= a;
    aw_valid <= 1'b1;
    w_data   <= d;
    w_strb   <= s;
    w_valid  <= 1'b1;
    b_ready  <= 1'b1;
    while (!b_d) begin
      @(posedge clk_i);
      if (aw_valid && aw_ready === 1'b1) aw_valid <= 1'b0;
      if (w_valid && w_ready === 1'b1) w_valid <= 1'b0;
      if (b_valid === 1'b1) begin
        chk(48'(b_resp), 48'(er), "bresp");
        b_ready <= 1'b0;
        b_d = 1'b1;
      end
    end
  endtask

  task automatic axi_rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit r_d;
    r_d = 1'b0;
    @(posedge clk_i);
    ar_addr  <= a;
    ar_valid <= 1'b1;
    r_ready  <= 1'b1;
    while (!r_d) begin
      @(posedge clk_i);
      if (ar_valid && ar_ready === 1'b1) ar_valid <= 1'b0;
      if (r_valid === 1'b1) begin
        chk(48'(r_data), 48'(ed), "rdata");
        chk(48'(r_resp), 48'(er), "rresp");
        r_ready <= 1'b0;
        r_d = 1'b1;
      end
    end
  endtask

  // Lane-aware shadow update; unassigned bits never stick
  task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
    axi_wr(OFFS[i], d, s, iprb_pkg::RESP_OKAY);
    if (s[0]) sh[i][7:0] = d[7:0];
    if (s[1]) sh[i][15:8] = d[15:8];
    sh[i] = sh[i] & MASKS[i];
  endtask

  task automatic rd_all();
    for (int i = 0; i < 7; i++) axi_rd(OFFS[i], {16'h0000, sh[i]}, iprb_pkg::RESP_OKAY);
  endtask

  // Levels must already show on the cycle after the write response
  task automatic chk_lv();
    logic [47:0] e;
    logic [15:0] ee;
    @(negedge clk_i);
    e = exp_lv();
    for (int k = 0; k < 16; k++) ee[k] = |e[k*3 +: 3];
    chk(lv, e, "levels");
    chk(48'(en), 48'(ee), "enables");
  endtask

  task automatic t_reset();
    mdl_reset();
    rd_all();
    chk_lv();
  endtask

  task automatic t_ones();
    for (int i = 0; i < 7; i++) wr(i, 32'hFFFFFFFF, 4'hF);
    chk_lv();
    rd_all();
  endtask

  task automatic t_codes();
    logic [31:0] d;
    for (int c = 0; c < 8; c++) begin
      for (int i = 0; i < 7; i++) begin
        d = 32'h00000000;
        for (int n = 0; n < 4; n++) d[4*n +: 3] = 3'(c + n + i);
        wr(i, d, 4'hF);
        chk_lv();
      end
      rd_all();
    end
  endtask

  task automatic t_lanes();
    wr(1, 32'h00000000, 4'hF);
    wr(1, 32'hFFFFFFFF, 4'h1);
    wr(1, 32'hFFFFFFFF, 4'hC);
    rd_all();
    wr(1, 32'hFFFFFFFF, 4'h2);
    chk_lv();
    rd_all();
  endtask

  task automatic t_unmapped();
    axi_wr(5'h1C, 32'hFFFFFFFF, 4'hF, iprb_pkg::RESP_SLVERR);
    axi_rd(5'h1C, 32'h00000000, iprb_pkg::RESP_SLVERR);
    rd_all();
  endtask

  task automatic t_reset2();
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_ones();
    t_codes();
    t_lanes();
    t_unmapped();
    t_reset2();
    test_done();
  end
endmodule
